// file: dv/testbench.sv
`timescale 1ns/10ps
module testbench;
  import csft_pkg::*;
  // ==========================================
  // stimulus and observed signals
  logic clk, reset, clk_en, reg_write, reg_read, op_valid;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, op_operand, acc_out;
  logic [2:0] reg_index;
  logic [4:0] bank_addr;
  logic [1:0] op_bytes, op_cycles;
  logic busy;
  csft_op_e op_code;
  int err_count, cmp_count;

  csft_core dut_u (.clk(clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .op_valid(op_valid), .op_code(op_code),
    .op_operand(op_operand), .op_operand_b(8'h00), .reg_index(reg_index),
    .acc_out(acc_out), .bank_addr(bank_addr), .op_bytes(op_bytes),
    .op_cycles(op_cycles), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================
  // shared tasks
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask

  // busy is counted, bounded so a stuck flag cannot hang the run
  task do_op(input csft_op_e c, input logic [7:0] v, output int n);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_operand <= v;
    @(posedge clk);
    op_valid <= 1'b0;
    n = 0;
    @(negedge clk);
    while (busy === 1'b1 && n < 8) begin
      n++;
      @(negedge clk);
    end
  endtask

  // ==========================================
  // scenarios
  task arith(input csft_op_e c, input logic [7:0] a, input logic [7:0] b,
             input logic [7:0] p, input logic [7:0] ea, input logic [2:0] ef);
    int n;
    wr(CSFT_ADDR_ACC, a);
    wr(CSFT_ADDR_PSW, p);
    do_op(c, b, n);
    chk(acc_out, ea);
    rd(CSFT_ADDR_PSW, {ef[2:1], p[5:3], ef[0], p[1], ^ea});
  endtask

  task timing(input csft_op_e c, input logic [1:0] b, input logic [1:0] cy);
    int n;
    do_op(c, 8'h5A, n);
    chk({op_bytes, op_cycles, n[3:0]}, {b, cy, 2'b00, cy - 2'h1});
    rd(CSFT_ADDR_TIMING, {4'h0, b, cy});
  endtask

  task test_status;
    rd(CSFT_ADDR_PSW, 8'h00);
    chk(acc_out, 8'h00);
    rd(CSFT_ADDR_TIMING, 8'h00);
    wr(CSFT_ADDR_ACC, 8'h07);
    wr(CSFT_ADDR_PSW, 8'hFE);
    rd(CSFT_ADDR_PSW, 8'hFF);
    wr(CSFT_ADDR_ACC, 8'h03);
    wr(CSFT_ADDR_PSW, 8'h01);
    rd(CSFT_ADDR_PSW, 8'h00);
    wr(CSFT_ADDR_ACC, 8'h80);
    rd(CSFT_ADDR_PSW, 8'h01);
    rd(4'hF, 8'h00);
  endtask

  task test_bank;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      reg_index <= 3'(k + 2);
      wr(CSFT_ADDR_PSW, 8'(k << 3));
      @(negedge clk);
      chk({3'b000, bank_addr}, {3'b000, 2'(k), 3'(k + 2)});
    end
  endtask

  task test_flags;
    arith(CSFT_OP_ADD, 8'h7F, 8'h01, 8'h00, 8'h80, 3'b011);
    arith(CSFT_OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h00, 3'b110);
    arith(CSFT_OP_ADD, 8'h01, 8'h02, 8'hC4, 8'h03, 3'b000);
    arith(CSFT_OP_ADD_WITH_CARRY, 8'h0E, 8'h01, 8'h80, 8'h10, 3'b010);
    arith(CSFT_OP_SUBTRACT_WITH_BORROW, 8'h00, 8'h01, 8'h00, 8'hFF, 3'b110);
    arith(CSFT_OP_SUBTRACT_WITH_BORROW, 8'h80, 8'h01, 8'h00, 8'h7F, 3'b011);
    arith(CSFT_OP_SUBTRACT_WITH_BORROW, 8'h10, 8'h01, 8'h80, 8'h0E, 3'b010);
    arith(CSFT_OP_MUL, 8'h0F, 8'h11, 8'hC4, 8'hFF, 3'b000);
    arith(CSFT_OP_MUL, 8'h10, 8'h10, 8'h00, 8'h00, 3'b001);
    arith(CSFT_OP_DIV, 8'h07, 8'h00, 8'h80, 8'h07, 3'b001);
    arith(CSFT_OP_DIV, 8'h09, 8'h02, 8'h04, 8'h04, 3'b000);
    arith(CSFT_OP_RLC, 8'h81, 8'h00, 8'h44, 8'h02, 3'b111);
    arith(CSFT_OP_RRC, 8'h01, 8'h00, 8'h80, 8'h80, 3'b100);
    arith(CSFT_OP_LOW_NIBBLE_EXCHANGE, 8'hA5, 8'h3C, 8'h00, 8'hAC, 3'b000);
    arith(CSFT_OP_MOV_IND, 8'h00, 8'h96, 8'h00, 8'h96, 3'b000);
  endtask

  task test_timing;
    timing(CSFT_OP_EXTERNAL_DATA_MOVE, 2'h1, CSFT_CYC_3);
    timing(CSFT_OP_CODE_MEMORY_READ, 2'h1, CSFT_CYC_3);
    timing(CSFT_OP_LOW_NIBBLE_EXCHANGE, 2'h1, CSFT_CYC_2);
    timing(CSFT_OP_MOV_IND, 2'h1, CSFT_CYC_2);
    timing(CSFT_OP_MOV_REG, 2'h1, CSFT_CYC_1);
    timing(CSFT_OP_RLC, 2'h1, CSFT_CYC_1);
    timing(CSFT_OP_RRC, 2'h1, CSFT_CYC_1);
    timing(CSFT_OP_MOV_DATA_POINTER, 2'h3, CSFT_CYC_3);
    timing(CSFT_OP_XRL_DIR, 2'h3, CSFT_CYC_3);
    timing(CSFT_OP_PUSHPOP, 2'h2, CSFT_CYC_2);
    timing(CSFT_OP_MOV_DD, 2'h3, CSFT_CYC_3);
  endtask

  // mid-run reset must clear everything the earlier scenarios left behind
  task test_reset;
    wr(CSFT_ADDR_ACC, 8'h07);
    wr(CSFT_ADDR_PSW, 8'hFE);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk(acc_out, 8'h00);
    chk({3'b000, bank_addr}, {5'h00, reg_index});
    rd(CSFT_ADDR_PSW, 8'h00);
    rd(CSFT_ADDR_TIMING, 8'h00);
  endtask

  // with the enable low, neither a write nor an operation may land
  task test_freeze;
    int n;
    wr(CSFT_ADDR_ACC, 8'h00);
    do_op(CSFT_OP_MOV_REG, 8'hC3, n);
    @(posedge clk);
    clk_en <= 1'b0;
    wr(CSFT_ADDR_ACC, 8'h55);
    do_op(CSFT_OP_EXTERNAL_DATA_MOVE, 8'h33, n);
    chk(8'(n), 8'h00);
    chk(acc_out, 8'hC3);
    @(posedge clk);
    clk_en <= 1'b1;
    rd(CSFT_ADDR_TIMING, 8'h05);
  endtask

  // ==========================================
  // run control
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    op_valid = 1'b0;
    op_code = CSFT_OP_NONE;
    op_operand = 8'h00;
    reg_index = 3'h0;
    err_count = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    test_status();
    test_bank();
    test_flags();
    test_timing();
    test_reset();
    test_freeze();
    finish_test();
  end

  // far beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test();
  end
endmodule

// file: hdl/csft_core.sv
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module csft_core
  import csft_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // operation issue
  input wire logic op_valid,
  input wire csft_pkg::csft_op_e op_code,
  input wire logic [7:0] op_operand,
  input wire logic [7:0] op_operand_b,
  input wire logic [2:0] reg_index,
  // results
  output logic [7:0] acc_out,
  output logic [4:0] bank_addr,
  output logic [1:0] op_bytes,
  output logic [1:0] op_cycles,
  output logic busy
);
  import csft_pkg::*;

  // ==========================================
  // state
  logic cy_reg, ac_reg, ov_reg, uf0_reg, uf1_reg;
  logic [1:0] bs_reg;
  logic [7:0] acc_reg, acc_next;
  logic cy_next, ac_next, ov_next;
  logic [1:0] cnt_reg;
  logic [1:0] tbytes, tcycles;
  logic [7:0] psw_view;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [15:0] prod;
  logic arith;
  logic start;

  assign start = op_valid && !busy;
  assign busy = (cnt_reg != 2'h0);

  csft_timing u_timing (
    .op(op_code),
    .bytes(tbytes),
    .cycles(tcycles)
  );

  // ==========================================
  // arithmetic
  // a divide-by-zero leaves the accumulator unchanged as a defined choice
  always_comb begin
    acc_next = acc_reg;
    cy_next = cy_reg;
    ac_next = ac_reg;
    ov_next = ov_reg;
    sum9 = 9'h000;
    sum5 = 5'h00;
    prod = 16'h0000;
    arith = 1'b0;
    case (op_code)
      CSFT_OP_ADD, CSFT_OP_ADD_WITH_CARRY: begin
        arith = 1'b1;
        sum9 = {1'b0, acc_reg} + {1'b0, op_operand}
             + {8'h00, (op_code == CSFT_OP_ADD_WITH_CARRY) & cy_reg};
        sum5 = {1'b0, acc_reg[3:0]} + {1'b0, op_operand[3:0]}
             + {4'h0, (op_code == CSFT_OP_ADD_WITH_CARRY) & cy_reg};
        acc_next = sum9[7:0];
        cy_next = sum9[8];
        ac_next = sum5[4];
        ov_next = (acc_reg[7] == op_operand[7]) && (sum9[7] != acc_reg[7]);
      end
      CSFT_OP_SUBTRACT_WITH_BORROW: begin
        arith = 1'b1;
        sum9 = {1'b0, acc_reg} - {1'b0, op_operand} - {8'h00, cy_reg};
        sum5 = {1'b0, acc_reg[3:0]} - {1'b0, op_operand[3:0]} - {4'h0, cy_reg};
        acc_next = sum9[7:0];
        cy_next = sum9[8];
        ac_next = sum5[4];
        ov_next = (acc_reg[7] != op_operand[7]) && (sum9[7] != acc_reg[7]);
      end
      CSFT_OP_MUL: begin
        arith = 1'b1;
        prod = 16'(acc_reg) * 16'(op_operand);
        acc_next = prod[7:0];
        cy_next = 1'b0;
        ac_next = 1'b0;
        ov_next = (prod > {8'h00, CSFT_MUL_LIMIT});
      end
      CSFT_OP_DIV: begin
        arith = 1'b1;
        cy_next = 1'b0;
        ac_next = 1'b0;
        if (op_operand == 8'h00) begin
          ov_next = 1'b1;
        end else begin
          acc_next = acc_reg / op_operand;
          ov_next = 1'b0;
        end
      end
      CSFT_OP_RLC: begin
        acc_next = {acc_reg[6:0], cy_reg};
        cy_next = acc_reg[7];
      end
      CSFT_OP_RRC: begin
        acc_next = {cy_reg, acc_reg[7:1]};
        cy_next = acc_reg[0];
      end
      CSFT_OP_LOW_NIBBLE_EXCHANGE: begin
        acc_next = {acc_reg[7:4], op_operand[3:0]};
      end
      CSFT_OP_MOV_IND, CSFT_OP_MOV_REG, CSFT_OP_EXTERNAL_DATA_MOVE, CSFT_OP_CODE_MEMORY_READ: begin
        acc_next = op_operand;
      end
      CSFT_OP_XRL_DIR: begin
        acc_next = acc_reg;
      end
      default: begin
        acc_next = acc_reg;
      end
    endcase
  end

  // ==========================================
  // accumulator and flags
  // an operation wins over a same-cycle software write
  always_ff @(posedge clk) begin
    if (reset) begin
      acc_reg <= 8'h00;
    end else if (clk_en) begin
      if (start) begin
        acc_reg <= acc_next;
      end else if (reg_write && reg_addr == CSFT_ADDR_ACC) begin
        acc_reg <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cy_reg <= CSFT_PSW_RESET[CSFT_CY_BIT];
      ac_reg <= CSFT_PSW_RESET[CSFT_AC_BIT];
      ov_reg <= CSFT_PSW_RESET[CSFT_OV_BIT];
    end else if (clk_en) begin
      if (start) begin
        cy_reg <= cy_next;
        ac_reg <= ac_next;
        ov_reg <= ov_next;
      end else if (reg_write && reg_addr == CSFT_ADDR_PSW) begin
        cy_reg <= reg_wdata[CSFT_CY_BIT];
        ac_reg <= reg_wdata[CSFT_AC_BIT];
        ov_reg <= reg_wdata[CSFT_OV_BIT];
      end
    end
  end

  // software-only state, hardware never alters it
  always_ff @(posedge clk) begin
    if (reset) begin
      uf0_reg <= CSFT_PSW_RESET[CSFT_UF0_BIT];
      uf1_reg <= CSFT_PSW_RESET[CSFT_UF1_BIT];
      bs_reg <= CSFT_PSW_RESET[CSFT_BS_HI:CSFT_BS_LO];
    end else if (clk_en && reg_write && reg_addr == CSFT_ADDR_PSW) begin
      uf0_reg <= reg_wdata[CSFT_UF0_BIT];
      uf1_reg <= reg_wdata[CSFT_UF1_BIT];
      bs_reg <= reg_wdata[CSFT_BS_HI:CSFT_BS_LO];
    end
  end

  // ==========================================
  // cycle counting
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg <= 2'h0;
      op_bytes <= 2'h0;
      op_cycles <= 2'h0;
    end else if (clk_en) begin
      if (start) begin
        cnt_reg <= tcycles - CSFT_CYC_1;
        op_bytes <= tbytes;
        op_cycles <= tcycles;
      end else if (busy) begin
        cnt_reg <= cnt_reg - 2'h1;
      end
    end
  end

  // ==========================================
  // status view and read port
  // parity is combinational so it can never go stale
  assign psw_view = {cy_reg, ac_reg, uf0_reg, bs_reg, ov_reg, uf1_reg, ^acc_reg};
  assign acc_out = acc_reg;
  assign bank_addr = {bs_reg, reg_index} & 5'h1F;

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_read && reg_addr == CSFT_ADDR_PSW) begin
        reg_rdata <= psw_view;
      end else if (reg_read && reg_addr == CSFT_ADDR_ACC) begin
        reg_rdata <= acc_reg;
      end else if (reg_read && reg_addr == CSFT_ADDR_TIMING) begin
        reg_rdata <= {4'h0, op_bytes, op_cycles};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ==========================================
  // checks
  // read port: a registered copy of the status view, zero when idle; then the bank address map
  a_parity_tracks: assert property (@(posedge clk) disable iff (reset)
    $past(clk_en && reg_read && reg_addr == CSFT_ADDR_PSW && !reset)
    |-> reg_rdata == $past(psw_view))
    else $error("parity view mismatch");
  a_parity_now: assert property (@(posedge clk) disable iff (reset)
    $past(clk_en && reg_read && reg_addr == CSFT_ADDR_PSW && !reset)
    |-> reg_rdata[CSFT_PAR_BIT] == ^$past(acc_reg))
    else $error("parity flag wrong");
  a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
    clk_en && !reg_read |=> reg_rdata == 8'h00)
    else $error("read data not cleared");
  a_bank_base: assert property (@(posedge clk) disable iff (reset)
    bank_addr == bs_reg * CSFT_BANK_SIZE + {2'b00, reg_index})
    else $error("bank map wrong");
  // flags worked out apart from the datapath sums
  a_add_carry: assert property (@(posedge clk) disable iff (reset)
    clk_en && start && op_code == CSFT_OP_ADD
    |=> cy_reg == (9'($past(acc_reg)) + 9'($past(op_operand)) > 9'h0FF)
    && ac_reg == (5'($past(acc_reg[3:0])) + 5'($past(op_operand[3:0])) > 5'h0F))
    else $error("add flags wrong");
  a_subtract_with_borrow_borrow: assert property (@(posedge clk) disable iff (reset)
    clk_en && start && op_code == CSFT_OP_SUBTRACT_WITH_BORROW
    |=> cy_reg == (9'($past(acc_reg)) < 9'($past(op_operand)) + 9'($past(cy_reg))))
    else $error("subtract borrow wrong");
  a_add_with_carry_half: assert property (@(posedge clk) disable iff (reset)
    clk_en && start && op_code == CSFT_OP_ADD_WITH_CARRY
    |=> ac_reg == (5'($past(acc_reg[3:0])) + 5'($past(op_operand[3:0]))
    + 5'($past(cy_reg)) > 5'h0F))
    else $error("add carry half flag wrong");
  a_subtract_with_borrow_half: assert property (@(posedge clk) disable iff (reset)
    clk_en && start && op_code == CSFT_OP_SUBTRACT_WITH_BORROW
    |=> ac_reg == (5'($past(acc_reg[3:0])) < 5'($past(op_operand[3:0]))
    + 5'($past(cy_reg))))
    else $error("subtract half borrow wrong");
  a_add_overflow: assert property (@(posedge clk) disable iff (reset)
    clk_en && start && op_code == CSFT_OP_ADD
    |=> ov_reg == ($past(acc_reg[7]) == $past(op_operand[7]) && acc_reg[7] != $past(acc_reg[7])))
    else $error("signed overflow wrong");
  a_mul_ov: assert property (@(posedge clk) disable iff (reset)
    clk_en && start && op_code == CSFT_OP_MUL
    |=> ov_reg == (16'($past(acc_reg)) * 16'($past(op_operand)) > 16'h00FF))
    else $error("multiply overflow wrong");
  a_mul_div_clear: assert property (@(posedge clk) disable iff (reset)
    clk_en && start && (op_code == CSFT_OP_MUL || op_code == CSFT_OP_DIV)
    |=> !cy_reg && !ac_reg)
    else $error("carry not cleared");
  a_div_zero_ov: assert property (@(posedge clk) disable iff (reset)
    clk_en && start && op_code == CSFT_OP_DIV && op_operand == 8'h00
    |=> ov_reg)
    else $error("divide by zero missed");
  a_div_ok_clear: assert property (@(posedge clk) disable iff (reset)
    clk_en && start && op_code == CSFT_OP_DIV && op_operand != 8'h00 |=> !ov_reg)
    else $error("divide overflow not cleared");
  a_flags_kept: assert property (@(posedge clk) disable iff (reset)
    clk_en && start && !arith && op_code != CSFT_OP_RLC && op_code != CSFT_OP_RRC
    |=> $stable(cy_reg) && $stable(ac_reg) && $stable(ov_reg))
    else $error("flags moved by a plain move");
  a_rlc_ninth: assert property (@(posedge clk) disable iff (reset)
    clk_en && start && op_code == CSFT_OP_RLC |=> cy_reg == $past(acc_reg[7])
    && acc_reg[0] == $past(cy_reg))
    else $error("rotate through carry wrong");
  a_rrc_ninth: assert property (@(posedge clk) disable iff (reset)
    clk_en && start && op_code == CSFT_OP_RRC |=> cy_reg == $past(acc_reg[0])
    && acc_reg[7] == $past(cy_reg))
    else $error("rotate right through carry wrong");
  a_low_nibble_exchange_upper: assert property (@(posedge clk) disable iff (reset)
    clk_en && start && op_code == CSFT_OP_LOW_NIBBLE_EXCHANGE
    |=> acc_reg[7:4] == $past(acc_reg[7:4]))
    else $error("upper nibble changed");
  // cycle and byte counts; a frozen clock would stretch them, so they stand aside then
  a_external_data_move_three: assert property (@(posedge clk) disable iff (reset || !clk_en)
    start && op_code == CSFT_OP_EXTERNAL_DATA_MOVE |=> op_bytes == 2'h1 && busy [*2] ##1 !busy)
    else $error("external move timing wrong");
  a_code_memory_read_three: assert property (@(posedge clk) disable iff (reset || !clk_en)
    start && op_code == CSFT_OP_CODE_MEMORY_READ
    |=> op_cycles == 2'h3 && op_bytes == 2'h1 && busy ##1 busy ##1 !busy)
    else $error("code read timing wrong");
  a_low_nibble_exchange_two: assert property (@(posedge clk) disable iff (reset || !clk_en)
    start && op_code == CSFT_OP_LOW_NIBBLE_EXCHANGE |=> op_cycles == 2'h2 && busy ##1 !busy)
    else $error("nibble exchange timing wrong");
  a_ind_two: assert property (@(posedge clk) disable iff (reset || !clk_en)
    start && op_code == CSFT_OP_MOV_IND |=> op_cycles == 2'h2 && busy ##1 !busy)
    else $error("indirect load timing wrong");
  a_reg_one: assert property (@(posedge clk) disable iff (reset || !clk_en)
    start && op_code == CSFT_OP_MOV_REG |=> op_cycles == 2'h1 && op_bytes == 2'h1 && !busy)
    else $error("register move timing wrong");
  a_rotate_one: assert property (@(posedge clk) disable iff (reset || !clk_en)
    start && (op_code == CSFT_OP_RLC || op_code == CSFT_OP_RRC)
    |=> op_cycles == 2'h1 && op_bytes == 2'h1 && !busy)
    else $error("rotate timing wrong");
  a_data_pointer_three: assert property (@(posedge clk) disable iff (reset || !clk_en)
    start && op_code == CSFT_OP_MOV_DATA_POINTER |=> op_bytes == 2'h3 && busy ##1 busy ##1 !busy)
    else $error("pointer load timing wrong");
  a_xrl_three: assert property (@(posedge clk) disable iff (reset || !clk_en)
    start && op_code == CSFT_OP_XRL_DIR |=> op_bytes == 2'h3 && busy ##1 busy ##1 !busy)
    else $error("direct xor timing wrong");
  a_pushpop_two: assert property (@(posedge clk) disable iff (reset || !clk_en)
    start && op_code == CSFT_OP_PUSHPOP |=> op_bytes == 2'h2 && busy ##1 !busy)
    else $error("push pop timing wrong");
  a_dd_three: assert property (@(posedge clk) disable iff (reset || !clk_en)
    start && op_code == CSFT_OP_MOV_DD |=> op_bytes == 2'h3 && busy ##1 busy ##1 !busy)
    else $error("direct move timing wrong");
  a_busy_refuse: assert property (@(posedge clk) disable iff (reset)
    busy |=> $stable(op_bytes) && $stable(op_cycles))
    else $error("operation taken while busy");
  // software-side state and the clock enable
  a_user_flags: assert property (@(posedge clk) disable iff (reset)
    !(clk_en && reg_write && reg_addr == CSFT_ADDR_PSW)
    |=> $stable(uf0_reg) && $stable(uf1_reg))
    else $error("user flag changed by hardware");
  a_freeze_hold: assert property (@(posedge clk) disable iff (reset)
    !clk_en |=> $stable(acc_reg) && $stable(cy_reg) && $stable(cnt_reg)
    && $stable(reg_rdata) && $stable(bs_reg) && $stable(op_cycles))
    else $error("state moved while frozen");
endmodule

// file: hdl/csft_timing.sv
`timescale 1ns/10ps
module csft_timing
  import csft_pkg::*;
(
  // operation
  input wire csft_pkg::csft_op_e op,
  // counts
  output logic [1:0] bytes,
  output logic [1:0] cycles
);
  import csft_pkg::*;

  always_comb begin
    bytes = CSFT_CYC_1;
    cycles = CSFT_CYC_1;
    case (op)
      CSFT_OP_EXTERNAL_DATA_MOVE: begin
        cycles = CSFT_CYC_3;
      end
      CSFT_OP_CODE_MEMORY_READ: begin
        cycles = CSFT_CYC_3;
      end
      CSFT_OP_LOW_NIBBLE_EXCHANGE: begin
        cycles = CSFT_CYC_2;
      end
      CSFT_OP_MOV_IND: begin
        cycles = CSFT_CYC_2;
      end
      CSFT_OP_MOV_DATA_POINTER: begin
        bytes = CSFT_CYC_3;
        cycles = CSFT_CYC_3;
      end
      CSFT_OP_XRL_DIR: begin
        bytes = CSFT_CYC_3;
        cycles = CSFT_CYC_3;
      end
      CSFT_OP_PUSHPOP: begin
        bytes = CSFT_CYC_2;
        cycles = CSFT_CYC_2;
      end
      CSFT_OP_MOV_DD: begin
        bytes = CSFT_CYC_3;
        cycles = CSFT_CYC_3;
      end
      default: begin
        cycles = CSFT_CYC_1;
      end
    endcase
  end
endmodule

// file: include/csft_pkg.sv
package csft_pkg;
  // ==========================================
  // status word layout
  localparam int unsigned CSFT_CY_BIT = 7;
  localparam int unsigned CSFT_AC_BIT = 6;
  localparam int unsigned CSFT_UF0_BIT = 5;
  localparam int unsigned CSFT_BS_HI = 4;
  localparam int unsigned CSFT_BS_LO = 3;
  localparam int unsigned CSFT_OV_BIT = 2;
  localparam int unsigned CSFT_UF1_BIT = 1;
  localparam int unsigned CSFT_PAR_BIT = 0;
  localparam logic [7:0] CSFT_PSW_RESET = 8'h00;
  localparam logic [7:0] CSFT_MUL_LIMIT = 8'hFF;
  localparam logic [4:0] CSFT_BANK_SIZE = 5'h08;
  // ==========================================
  // register addresses (own choice)
  localparam logic [3:0] CSFT_ADDR_PSW = 4'h0;
  localparam logic [3:0] CSFT_ADDR_ACC = 4'h1;
  localparam logic [3:0] CSFT_ADDR_TIMING = 4'h2;
  // ==========================================
  // operations
  typedef enum logic [4:0] {
    CSFT_OP_NONE, CSFT_OP_ADD, CSFT_OP_ADD_WITH_CARRY, CSFT_OP_SUBTRACT_WITH_BORROW, CSFT_OP_MUL, CSFT_OP_DIV,
    CSFT_OP_RLC, CSFT_OP_RRC, CSFT_OP_EXTERNAL_DATA_MOVE, CSFT_OP_CODE_MEMORY_READ, CSFT_OP_LOW_NIBBLE_EXCHANGE,
    CSFT_OP_MOV_IND, CSFT_OP_MOV_REG, CSFT_OP_MOV_DATA_POINTER, CSFT_OP_XRL_DIR,
    CSFT_OP_PUSHPOP, CSFT_OP_MOV_DD
  } csft_op_e;
  // ==========================================
  // byte and cycle counts
  localparam logic [1:0] CSFT_CYC_1 = 2'h1;
  localparam logic [1:0] CSFT_CYC_2 = 2'h2;
  localparam logic [1:0] CSFT_CYC_3 = 2'h3;
endpackage
